// file: rtl/fie_top.sv
// Module: invalid and denormal exception unit with its register slave
module fie_top (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_op_valid,
  input wire fie_pkg::fie_op_t i_op,
  input wire fie_pkg::fie_cls_t i_cls_a,
  input wire fie_pkg::fie_cls_t i_cls_b,
  input wire logic i_sign_a,
  input wire logic i_sign_b,
  input wire logic [1:0] i_tag_a,
  input wire logic [1:0] i_tag_b,
  input wire logic [1:0] i_tag_dst,
  input wire logic i_two_src,
  input wire logic i_range_err,
  input wire logic i_load_ext,
  output logic o_op_done,
  output logic o_commit,
  output fie_pkg::fie_res_t o_result_sel,
  output logic o_fill_a,
  output logic o_fill_b,
  output logic o_normalize,
  output logic o_handler_req,
  output logic [2:0] o_proc_flags,
  output logic o_proc_flags_we
);
  logic rst_meta_q, rst_b_q;
  logic ack_q;
  logic [15:0] status_q, status_d;
  logic [15:0] control_q;
  logic [3:0] event_q;
  logic st_wr, cw_wr, take;
  logic inv_any, unmasked, masked_inv;
  fie_verdict_if vd ();

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_q <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_b_q <= rst_meta_q;
    end
  end

  fie_detect u_detect (
    .i_op(i_op),
    .i_cls_a(i_cls_a),
    .i_cls_b(i_cls_b),
    .i_sign_a(i_sign_a),
    .i_sign_b(i_sign_b),
    .i_tag_a(i_tag_a),
    .i_tag_b(i_tag_b),
    .i_tag_dst(i_tag_dst),
    .i_two_src(i_two_src),
    .i_range_err(i_range_err),
    .i_load_ext(i_load_ext),
    .vd(vd.det)
  );

  function automatic logic [15:0] be_merge(input logic [15:0] old,
    input logic [31:0] wd, input logic [3:0] be, input logic [15:0] m);
    logic [15:0] v;
    v = old;
    if (be[0]) v[7:0] = wd[7:0];
    if (be[1]) v[15:8] = wd[15:8];
    be_merge = v & m;
  endfunction

  // One wait state: every access answers at the second edge
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
  assign st_wr = i_avs_write && !ack_q &&
    (i_avs_address == fie_pkg::ADDR_STATUS);
  assign cw_wr = i_avs_write && !ack_q &&
    (i_avs_address == fie_pkg::ADDR_CONTROL);

  always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      ack_q <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      ack_q <= (i_avs_read || i_avs_write) && !ack_q;
      if (i_avs_read && !ack_q) begin
        case (i_avs_address)
          fie_pkg::ADDR_STATUS: o_avs_readdata <= {16'h0000, status_q};
          fie_pkg::ADDR_CONTROL: o_avs_readdata <= {16'h0000, control_q};
          fie_pkg::ADDR_EVENT: o_avs_readdata <= {28'h0000000, event_q};
          default: o_avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
    if (!rst_b_q) control_q <= fie_pkg::CONTROL_RST;
    else if (cw_wr) control_q <= be_merge(control_q, i_avs_writedata,
      i_avs_byteenable, fie_pkg::CONTROL_WMASK);
  end

  assign take = i_op_valid;
  assign inv_any = vd.stack_fault || vd.invalid;
  assign masked_inv = inv_any && control_q[fie_pkg::CW_INVALID];
  // Invalid outranks denormal, so one instruction raises only one of them
  assign unmasked = (inv_any && !control_q[fie_pkg::CW_INVALID]) ||
    (!inv_any && vd.denormal && !control_q[fie_pkg::CW_DENORMAL]);

  // Software write first, hardware sets after: a set never gets lost
  always_comb begin
    status_d = status_q;
    if (st_wr) status_d = be_merge(status_q, i_avs_writedata,
      i_avs_byteenable, fie_pkg::STATUS_WMASK);
    if (take) begin
      if (vd.stack_fault) begin
        status_d[fie_pkg::SW_INVALID] = 1'b1;
        status_d[fie_pkg::SW_STACK] = 1'b1;
        status_d[fie_pkg::SW_CC1] = vd.overflow;
      end else if (vd.invalid) begin
        status_d[fie_pkg::SW_INVALID] = 1'b1;
        if (masked_inv && vd.unordered && i_op != fie_pkg::OP_CMPF) begin
          status_d[fie_pkg::SW_CC0] = 1'b1;
          status_d[fie_pkg::SW_CC2] = 1'b1;
          status_d[fie_pkg::SW_CC3] = 1'b1;
        end
        if (masked_inv && vd.clr_cc2) begin
          status_d[fie_pkg::SW_CC2] = 1'b0;
        end
      end else if (vd.denormal) begin
        status_d[fie_pkg::SW_DENORMAL] = 1'b1;
      end
      if (unmasked) status_d[fie_pkg::SW_SUMMARY] = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
    if (!rst_b_q) status_q <= fie_pkg::STATUS_RST;
    else status_q <= status_d;
  end

  always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
    if (!rst_b_q) event_q <= 4'h0;
    else if (take) event_q <= {vd.denormal && !inv_any, vd.invalid,
      vd.stack_fault, vd.overflow};
  end

  // Unmasked faults commit nothing, so stack pointer and sources stay put
  always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      o_op_done <= 1'b0;
      o_commit <= 1'b0;
      o_result_sel <= fie_pkg::RES_NORMAL;
      o_fill_a <= 1'b0;
      o_fill_b <= 1'b0;
      o_normalize <= 1'b0;
      o_handler_req <= 1'b0;
      o_proc_flags <= 3'h0;
      o_proc_flags_we <= 1'b0;
    end else begin
      o_op_done <= take;
      o_commit <= take && !unmasked;
      o_handler_req <= take && unmasked;
      o_result_sel <= unmasked ? fie_pkg::RES_NONE : vd.res;
      o_fill_a <= take && masked_inv && vd.fill_a;
      o_fill_b <= take && masked_inv && vd.fill_b;
      o_normalize <= take && !unmasked && !inv_any && vd.normalize;
      o_proc_flags_we <= take && masked_inv && vd.unordered &&
        (i_op == fie_pkg::OP_CMPF);
      o_proc_flags <= fie_pkg::CC_UNORDERED;
    end
  end

  sequence s_stack_fault;
    i_op_valid && vd.stack_fault;
  endsequence

  sequence s_arith_fault;
    i_op_valid && vd.invalid && !st_wr;
  endsequence

  property p_stack_flags;
    @(posedge i_ref_clk) disable iff (!rst_b_q)
    s_stack_fault |=> status_q[fie_pkg::SW_INVALID] &&
      status_q[fie_pkg::SW_STACK];
  endproperty
  a_stack_flags: assert property (p_stack_flags)
    else $error("stack fault did not set both flags");

  property p_cc1;
    @(posedge i_ref_clk) disable iff (!rst_b_q)
    s_stack_fault |=> status_q[fie_pkg::SW_CC1] == $past(vd.overflow);
  endproperty
  a_cc1: assert property (p_cc1)
    else $error("condition code one wrong after stack fault");

  property p_sf_kept;
    @(posedge i_ref_clk) disable iff (!rst_b_q)
    s_arith_fault |=> status_q[fie_pkg::SW_STACK] ==
      $past(status_q[fie_pkg::SW_STACK]) && status_q[fie_pkg::SW_INVALID];
  endproperty
  a_sf_kept: assert property (p_sf_kept)
    else $error("invalid operand changed stack flag");

  property p_handler;
    @(posedge i_ref_clk) disable iff (!rst_b_q)
    (i_op_valid && unmasked) |=> o_handler_req && !o_commit &&
      o_result_sel == fie_pkg::RES_NONE ##1 !o_handler_req;
  endproperty
  a_handler: assert property (p_handler)
    else $error("unmasked fault did not hand off cleanly");

  property p_masked_stack;
    @(posedge i_ref_clk) disable iff (!rst_b_q)
    (s_stack_fault ##0 control_q[fie_pkg::CW_INVALID] &&
      i_op != fie_pkg::OP_CMP && i_op != fie_pkg::OP_CMPF &&
      i_op != fie_pkg::OP_UCMP) |=> o_commit &&
      o_result_sel != fie_pkg::RES_NORMAL;
  endproperty
  a_masked_stack: assert property (p_masked_stack)
    else $error("masked stack fault wrote no indefinite");

  property p_unordered;
    @(posedge i_ref_clk) disable iff (!rst_b_q)
    (s_arith_fault ##0 masked_inv && vd.unordered &&
      i_op == fie_pkg::OP_CMP) |=> status_q[fie_pkg::SW_CC0] &&
      status_q[fie_pkg::SW_CC2] && status_q[fie_pkg::SW_CC3];
  endproperty
  a_unordered: assert property (p_unordered)
    else $error("unordered compare codes not 111");

  property p_summary;
    @(posedge i_ref_clk) disable iff (!rst_b_q)
    (i_op_valid && unmasked) |=> status_q[fie_pkg::SW_SUMMARY];
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary flag missing after unmasked fault");

  property p_sticky;
    @(posedge i_ref_clk) disable iff (!rst_b_q)
    (status_q[fie_pkg::SW_INVALID] && !st_wr) |=>
      status_q[fie_pkg::SW_INVALID];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("invalid flag dropped without a write");

  property p_denormal;
    @(posedge i_ref_clk) disable iff (!rst_b_q)
    (i_op_valid && vd.denormal && !inv_any &&
      control_q[fie_pkg::CW_DENORMAL]) |=>
      status_q[fie_pkg::SW_DENORMAL] && o_commit && o_op_done;
  endproperty
  a_denormal: assert property (p_denormal)
    else $error("masked denormal did not complete");

  property p_ext_load;
    @(posedge i_ref_clk) disable iff (!rst_b_q)
    (i_op_valid && i_op == fie_pkg::OP_LOAD && i_load_ext) |->
      !vd.denormal;
  endproperty
  a_ext_load: assert property (p_ext_load)
    else $error("extended load raised denormal fault");

  property p_bus_answer;
    @(posedge i_ref_clk) disable iff (!rst_b_q)
    (i_avs_read && o_avs_waitrequest) |=> !o_avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("register read not answered in one wait state");
endmodule

// file: rtl/fie_pkg.sv
// Package: constants and types of the invalid and denormal exception unit
package fie_pkg;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_EVENT = 4'h8;
  localparam int SW_INVALID = 0;
  localparam int SW_DENORMAL = 1;
  localparam int SW_STACK = 6;
  localparam int SW_SUMMARY = 7;
  localparam int SW_CC0 = 8;
  localparam int SW_CC1 = 9;
  localparam int SW_CC2 = 10;
  localparam int SW_CC3 = 14;
  localparam int CW_INVALID = 0;
  localparam int CW_DENORMAL = 1;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] CONTROL_RST = 16'h0003;
  localparam logic [15:0] STATUS_WMASK = 16'h47C3;
  localparam logic [15:0] CONTROL_WMASK = 16'h0003;
  localparam logic [1:0] TAG_VALID = 2'h0;
  localparam logic [1:0] TAG_ZERO = 2'h1;
  localparam logic [1:0] TAG_SPECIAL = 2'h2;
  localparam logic [1:0] TAG_EMPTY = 2'h3;
  localparam logic [2:0] CC_UNORDERED = 3'h7;
  typedef enum logic [4:0] {
    OP_ADD = 5'h00, OP_SUB = 5'h01, OP_MUL = 5'h02, OP_DIV = 5'h03,
    OP_REM = 5'h04, OP_TRIG = 5'h05, OP_SQRT = 5'h06, OP_LOG = 5'h07,
    OP_LOGP1 = 5'h08, OP_CMP = 5'h09, OP_UCMP = 5'h0A, OP_CMPF = 5'h0B,
    OP_LOAD = 5'h0C, OP_STORE = 5'h0D, OP_STINT = 5'h0E, OP_STBCD = 5'h0F,
    OP_XCH = 5'h10, OP_OTHER = 5'h11
  } fie_op_t;
  typedef enum logic [2:0] {
    CLS_NORM = 3'h0, CLS_ZERO = 3'h1, CLS_INF = 3'h2, CLS_DENORM = 3'h3,
    CLS_QNAN = 3'h4, CLS_SNAN = 3'h5, CLS_UNSUP = 3'h6
  } fie_cls_t;
  typedef enum logic [2:0] {
    RES_NORMAL = 3'h0, RES_QNAN_INDEF = 3'h1, RES_QUIETED = 3'h2,
    RES_INT_INDEF = 3'h3, RES_BCD_INDEF = 3'h4, RES_NONE = 3'h5
  } fie_res_t;
endpackage

// file: rtl/fie_verdict_if.sv
// Interface: verdict of the fault detector towards the exception core
interface fie_verdict_if;
  logic stack_fault;
  logic overflow;
  logic invalid;
  logic denormal;
  logic unordered;
  logic clr_cc2;
  logic fill_a;
  logic fill_b;
  logic normalize;
  fie_pkg::fie_res_t res;
  modport det (output stack_fault, overflow, invalid, denormal, unordered,
    clr_cc2, fill_a, fill_b, normalize, res);
  modport core (input stack_fault, overflow, invalid, denormal, unordered,
    clr_cc2, fill_a, fill_b, normalize, res);
endinterface

// file: rtl/fie_detect.sv
// Module: combinational fault classification of one instruction
module fie_detect (
  input wire fie_pkg::fie_op_t i_op,
  input wire fie_pkg::fie_cls_t i_cls_a,
  input wire fie_pkg::fie_cls_t i_cls_b,
  input wire logic i_sign_a,
  input wire logic i_sign_b,
  input wire logic [1:0] i_tag_a,
  input wire logic [1:0] i_tag_b,
  input wire logic [1:0] i_tag_dst,
  input wire logic i_two_src,
  input wire logic i_range_err,
  input wire logic i_load_ext,
  fie_verdict_if.det vd
);
  function automatic logic has(input fie_pkg::fie_cls_t a,
    input fie_pkg::fie_cls_t b, input logic two, input fie_pkg::fie_cls_t c);
    has = (a == c) || (two && (b == c));
  endfunction

  logic snan, unsup, qnan, inf, den, cmp, ld, xch, ia;
  logic empty_a, empty_b;
  always_comb begin
    snan = has(i_cls_a, i_cls_b, i_two_src, fie_pkg::CLS_SNAN);
    unsup = has(i_cls_a, i_cls_b, i_two_src, fie_pkg::CLS_UNSUP);
    qnan = has(i_cls_a, i_cls_b, i_two_src, fie_pkg::CLS_QNAN);
    inf = has(i_cls_a, i_cls_b, i_two_src, fie_pkg::CLS_INF);
    den = has(i_cls_a, i_cls_b, i_two_src, fie_pkg::CLS_DENORM);
    cmp = (i_op == fie_pkg::OP_CMP) || (i_op == fie_pkg::OP_CMPF);
    ld = (i_op == fie_pkg::OP_LOAD);
    xch = (i_op == fie_pkg::OP_XCH);
    empty_a = (i_tag_a == fie_pkg::TAG_EMPTY);
    empty_b = i_two_src && (i_tag_b == fie_pkg::TAG_EMPTY);
    vd.overflow = ld && (i_tag_dst != fie_pkg::TAG_EMPTY);
    vd.stack_fault = vd.overflow || (!ld && !xch && (empty_a || empty_b));
    vd.fill_a = xch && empty_a;
    vd.fill_b = xch && empty_b;
    ia = snan || unsup;
    vd.unordered = (cmp || i_op == fie_pkg::OP_UCMP) && (qnan || snan);
    vd.clr_cc2 = 1'b0;
    case (i_op)
      fie_pkg::OP_CMP, fie_pkg::OP_CMPF: ia = ia || qnan;
      fie_pkg::OP_STINT, fie_pkg::OP_STBCD:
        ia = ia || qnan || inf || i_range_err;
      fie_pkg::OP_ADD: ia = ia || (i_cls_a == fie_pkg::CLS_INF &&
        i_cls_b == fie_pkg::CLS_INF && i_sign_a != i_sign_b);
      fie_pkg::OP_SUB: ia = ia || (i_cls_a == fie_pkg::CLS_INF &&
        i_cls_b == fie_pkg::CLS_INF && i_sign_a == i_sign_b);
      fie_pkg::OP_MUL: ia = ia || (inf &&
        has(i_cls_a, i_cls_b, 1'b1, fie_pkg::CLS_ZERO));
      fie_pkg::OP_DIV: ia = ia || (i_cls_a == i_cls_b &&
        (i_cls_a == fie_pkg::CLS_INF || i_cls_a == fie_pkg::CLS_ZERO));
      fie_pkg::OP_REM: begin
        vd.clr_cc2 = i_cls_b == fie_pkg::CLS_ZERO || i_cls_a == fie_pkg::CLS_INF;
        ia = ia || vd.clr_cc2;
      end
      fie_pkg::OP_TRIG: begin
        vd.clr_cc2 = i_cls_a == fie_pkg::CLS_INF;
        ia = ia || vd.clr_cc2;
      end
      fie_pkg::OP_SQRT, fie_pkg::OP_LOG: ia = ia || (i_sign_a &&
        i_cls_a != fie_pkg::CLS_ZERO && i_cls_a < fie_pkg::CLS_QNAN);
      fie_pkg::OP_LOGP1: ia = ia || i_range_err;
      fie_pkg::OP_XCH: ia = empty_a || empty_b;
      default: ia = ia;
    endcase
    vd.invalid = ia && !vd.stack_fault;
    // Extended loads carry denormals as they are; no fault there
    vd.denormal = den && !xch && !(ld && i_load_ext);
    vd.normalize = vd.denormal && ld;
    if (vd.stack_fault || vd.invalid) begin
      if (i_op == fie_pkg::OP_STINT) vd.res = fie_pkg::RES_INT_INDEF;
      else if (i_op == fie_pkg::OP_STBCD) vd.res = fie_pkg::RES_BCD_INDEF;
      else if (cmp || i_op == fie_pkg::OP_UCMP) vd.res = fie_pkg::RES_NONE;
      else if (xch) vd.res = fie_pkg::RES_NORMAL;
      else if (vd.invalid && snan && !unsup) vd.res = fie_pkg::RES_QUIETED;
      else vd.res = fie_pkg::RES_QNAN_INDEF;
    end else begin
      vd.res = fie_pkg::RES_NORMAL;
    end
  end
endmodule

// file: verif/fie_dp_model.sv
// Behavioural model of the execution datapath that feeds the op port
module fie_dp_model (
  input wire logic i_clk,
  output logic o_op_valid,
  output fie_pkg::fie_op_t o_op,
  output fie_pkg::fie_cls_t o_cls_a,
  output fie_pkg::fie_cls_t o_cls_b,
  output logic o_sign_a,
  output logic o_sign_b,
  output logic [1:0] o_tag_a,
  output logic [1:0] o_tag_b,
  output logic [1:0] o_tag_dst,
  output logic o_two_src,
  output logic o_range_err,
  output logic o_load_ext
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [21:0] f_q;
  assign o_op = fie_pkg::fie_op_t'(f_q[21:17]);
  assign o_cls_a = fie_pkg::fie_cls_t'(f_q[16:14]);
  assign o_cls_b = fie_pkg::fie_cls_t'(f_q[13:11]);
  assign {o_sign_a, o_sign_b, o_tag_a, o_tag_b, o_tag_dst} = f_q[10:3];
  assign {o_two_src, o_range_err, o_load_ext} = f_q[2:0];
  initial begin
    o_op_valid = 1'h0;
    f_q = 22'h0;
  end
  // Operand lines turn over after each op so a stale op never looks valid
  task automatic issue(input logic [21:0] f);
    @(posedge i_clk);
    o_op_valid <= 1'h1;
    f_q <= f;
    @(posedge i_clk);
    o_op_valid <= 1'h0;
    f_q <= ~f;
  endtask
endmodule

// file: verif/fie_top_test.sv
// Self-checking bench of the invalid and denormal exception unit
module fie_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] rdata;
  logic wait_req;
  logic op_valid, sign_a, sign_b, two_src, range_err, load_ext;
  logic [1:0] tag_a, tag_b, tag_dst;
  fie_pkg::fie_op_t op;
  fie_pkg::fie_cls_t cls_a, cls_b;
  logic done, commit, fill_a, fill_b, norm, hreq, pf_we;
  fie_pkg::fie_res_t res;
  logic [2:0] pf;
  logic [9:0] outv;
  logic [31:0] got;
  int err_total = 0;
  int num_checks = 0;
  int i;
  assign outv = {done, commit, hreq, fill_a, fill_b, norm, pf_we, res};
  always #4 clk = ~clk;
  fie_dp_model DP (.i_clk(clk), .o_op_valid(op_valid), .o_op(op),
    .o_cls_a(cls_a), .o_cls_b(cls_b), .o_sign_a(sign_a), .o_sign_b(sign_b),
    .o_tag_a(tag_a), .o_tag_b(tag_b), .o_tag_dst(tag_dst),
    .o_two_src(two_src), .o_range_err(range_err), .o_load_ext(load_ext));
  fie_top DUT (.i_ref_clk(clk), .i_rst_b(rst_b), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .i_op_valid(op_valid), .i_op(op),
    .i_cls_a(cls_a), .i_cls_b(cls_b), .i_sign_a(sign_a), .i_sign_b(sign_b),
    .i_tag_a(tag_a), .i_tag_b(tag_b), .i_tag_dst(tag_dst),
    .i_two_src(two_src), .i_range_err(range_err), .i_load_ext(load_ext),
    .o_op_done(done), .o_commit(commit), .o_result_sel(res),
    .o_fill_a(fill_a), .o_fill_b(fill_b), .o_normalize(norm),
    .o_handler_req(hreq), .o_proc_flags(pf), .o_proc_flags_we(pf_we));
  task automatic close_out();
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // Request held until waitrequest is seen low; read data taken then
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [15:0] d, input logic [3:0] b);
    int n;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= {16'h0, d};
    be <= b;
    // Waitrequest and read data are both taken at the rising edge
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (wait_req === 1'h0) begin
        got = rdata;
        break;
      end
    end
    if (n == 20) begin
      err_total++;
      close_out();
    end
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  task automatic rdchk(input string n, input logic [3:0] a,
    input logic [15:0] e);
    bus(1'h0, a, 16'h0, 4'h3);
    chk(n, {16'h0, e}, got);
  endtask
  task automatic clr();
    bus(1'h1, fie_pkg::ADDR_STATUS, 16'h0, 4'h3);
  endtask
  // Tags are {a, b, dst}; flags are {sign a, sign b, two, range, ext}
  task automatic op2(input logic [4:0] o, input logic [2:0] ca,
    input logic [2:0] cb, input logic [5:0] tg, input logic [4:0] fl);
    DP.issue({o, ca, cb, fl[4:3], tg, fl[2:0]});
    @(negedge clk);
  endtask
  // Masked arithmetic case; r[3] asks for a committed result r[2:0]
  task automatic tc(input logic [4:0] o, input logic [2:0] ca,
    input logic [2:0] cb, input logic [3:0] fl, input logic [15:0] pre,
    input logic [15:0] st, input logic [3:0] r);
    bus(1'h1, fie_pkg::ADDR_STATUS, pre, 4'h3);
    op2(o, ca, cb, 6'h03, {fl, 1'h0});
    if (r[3]) chk("outs", {22'h0, 7'h60, r[2:0]}, {22'h0, outv});
    rdchk("status", fie_pkg::ADDR_STATUS, st);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk);
    rdchk("status", fie_pkg::ADDR_STATUS, 16'h0000);
    rdchk("control", fie_pkg::ADDR_CONTROL, 16'h0003);
    rdchk("unmapped", 4'hC, 16'h0000);
    bus(1'h1, fie_pkg::ADDR_CONTROL, 16'h0000, 4'h2);
    rdchk("control", fie_pkg::ADDR_CONTROL, 16'h0003);
    for (i = 0; i < 3; i++) begin
      clr();
      op2(5'h0C, 3'h0, 3'h0, 6'(i), 5'h00);
      chk("outs", 32'h301, {22'h0, outv});
      rdchk("status", fie_pkg::ADDR_STATUS, 16'h0241);
    end
    rdchk("event", fie_pkg::ADDR_EVENT, 16'h0003);
    clr();
    op2(5'h0C, 3'h0, 3'h0, 6'h03, 5'h00);
    rdchk("status", fie_pkg::ADDR_STATUS, 16'h0000);
    op2(5'h00, 3'h0, 3'h0, 6'h33, 5'h04);
    chk("outs", 32'h301, {22'h0, outv});
    rdchk("status", fie_pkg::ADDR_STATUS, 16'h0041);
    clr();
    op2(5'h0D, 3'h0, 3'h0, 6'h33, 5'h00);
    rdchk("status", fie_pkg::ADDR_STATUS, 16'h0041);
    op2(5'h00, 3'h2, 3'h2, 6'h03, 5'h0C);
    rdchk("status", fie_pkg::ADDR_STATUS, 16'h0041);
    rdchk("event", fie_pkg::ADDR_EVENT, 16'h0004);
    tc(5'h00, 3'h2, 3'h2, 4'h6, 16'h0, 16'h1, 4'h9);
    tc(5'h01, 3'h2, 3'h2, 4'h2, 16'h0, 16'h1, 4'h9);
    tc(5'h02, 3'h2, 3'h1, 4'h2, 16'h0, 16'h1, 4'h9);
    tc(5'h03, 3'h1, 3'h1, 4'h2, 16'h0, 16'h1, 4'h9);
    tc(5'h03, 3'h2, 3'h2, 4'h2, 16'h0, 16'h1, 4'h9);
    tc(5'h04, 3'h0, 3'h1, 4'h2, 16'h400, 16'h1, 4'h9);
    tc(5'h04, 3'h2, 3'h0, 4'h2, 16'h400, 16'h1, 4'h9);
    tc(5'h05, 3'h2, 3'h0, 4'h0, 16'h400, 16'h1, 4'h9);
    tc(5'h06, 3'h0, 3'h0, 4'h8, 16'h0, 16'h1, 4'h9);
    tc(5'h06, 3'h1, 3'h0, 4'h8, 16'h0, 16'h0, 4'h8);
    tc(5'h07, 3'h0, 3'h0, 4'h8, 16'h0, 16'h1, 4'h9);
    tc(5'h08, 3'h0, 3'h0, 4'h9, 16'h0, 16'h1, 4'h9);
    tc(5'h00, 3'h6, 3'h0, 4'h2, 16'h0, 16'h1, 4'h9);
    tc(5'h02, 3'h5, 3'h0, 4'h2, 16'h0, 16'h1, 4'hA);
    tc(5'h0E, 3'h4, 3'h0, 4'h0, 16'h0, 16'h1, 4'hB);
    tc(5'h0E, 3'h0, 3'h0, 4'h1, 16'h0, 16'h1, 4'hB);
    tc(5'h0F, 3'h2, 3'h0, 4'h0, 16'h0, 16'h1, 4'hC);
    tc(5'h0F, 3'h0, 3'h0, 4'h1, 16'h0, 16'h1, 4'hC);
    tc(5'h09, 3'h4, 3'h0, 4'h2, 16'h0, 16'h4501, 4'h0);
    tc(5'h00, 3'h4, 3'h0, 4'h2, 16'h0, 16'h0, 4'h8);
    clr();
    op2(5'h0B, 3'h4, 3'h0, 6'h03, 5'h04);
    chk("proc flags", 32'hF, {28'h0, pf_we, pf});
    clr();
    op2(5'h10, 3'h0, 3'h0, 6'h30, 5'h04);
    chk("fill", 32'h2, {30'h0, fill_a, fill_b});
    op2(5'h10, 3'h0, 3'h0, 6'h3C, 5'h04);
    chk("fill", 32'h3, {30'h0, fill_a, fill_b});
    rdchk("status", fie_pkg::ADDR_STATUS, 16'h0001);
    clr();
    op2(5'h0C, 3'h3, 3'h0, 6'h03, 5'h00);
    chk("outs", 32'h310, {22'h0, outv});
    rdchk("status", fie_pkg::ADDR_STATUS, 16'h0002);
    clr();
    op2(5'h0C, 3'h3, 3'h0, 6'h03, 5'h01);
    chk("normalize", 32'h0, {31'h0, norm});
    rdchk("status", fie_pkg::ADDR_STATUS, 16'h0000);
    op2(5'h00, 3'h3, 3'h0, 6'h03, 5'h04);
    rdchk("status", fie_pkg::ADDR_STATUS, 16'h0002);
    // Unmasked: handler called, nothing committed, summary raised
    bus(1'h1, fie_pkg::ADDR_CONTROL, 16'h0000, 4'h3);
    clr();
    op2(5'h00, 3'h2, 3'h2, 6'h03, 5'h0C);
    chk("outs", 32'h285, {22'h0, outv});
    rdchk("status", fie_pkg::ADDR_STATUS, 16'h0081);
    op2(5'h00, 3'h0, 3'h0, 6'h03, 5'h04);
    rdchk("status", fie_pkg::ADDR_STATUS, 16'h0081);
    clr();
    op2(5'h0C, 3'h0, 3'h0, 6'h01, 5'h00);
    chk("outs", 32'h285, {22'h0, outv});
    rdchk("status", fie_pkg::ADDR_STATUS, 16'h02C1);
    clr();
    op2(5'h00, 3'h3, 3'h0, 6'h03, 5'h04);
    chk("outs", 32'h285, {22'h0, outv});
    rdchk("status", fie_pkg::ADDR_STATUS, 16'h0082);
    close_out();
  end
endmodule
